// *** hw/aat_alu.sv ***
// aat_alu: accumulator arithmetic and logic execution unit with per-instruction timing
// Overview of operation
// - add takes 1 byte/1 cycle with bank register, 2 cycles indirect, 2 bytes/2 cycles direct or immediate.
// - add_with_carry adds operand plus carry with the same lengths and cycles as add.
// - subtract_with_borrow subtracts operand and borrow; 1 cycle bank register, 2 cycles otherwise.
// - increment is 1 byte/1 cycle on acc or bank register, 2 cycles indirect, 2 bytes/2 cycles direct.
// - decrement is 1 cycle on acc or bank register, 2 cycles indirect, 2 bytes/2 cycles direct.
// - incrementing the 16-bit data_pointer is one byte and one cycle.
// - multiply_acc_by_second is one byte and 4 cycles.
// - decimal_adjust of the accumulator is one byte and one cycle.
// - logical_and into acc takes 1 cycle register, 2 cycles indirect, 2 bytes/2 cycles direct or immediate.
// - logical_and into a direct byte takes 2 bytes/2 cycles from acc and 3 bytes/3 cycles from immediate.
// - logical_or into acc times like logical_and: 1 cycle register, 2 cycles otherwise.
// - logical_or into a direct byte takes 2/2 from acc and 3/3 from immediate.
// - logical_xor takes 1 cycle register, 3 bytes/3 cycles immediate into direct byte, 2 cycles otherwise, 2 bytes/2 cycles acc into direct byte.
`timescale 1ns/1ns
module aat_alu (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // instruction issue
  input wire logic start,
  input wire aat_pkg::aat_op_t op,
  input wire aat_pkg::aat_form_t form,
  input wire logic [7:0] operand,
  // pipeline status
  output logic busy,
  output logic done,
  output logic [1:0] instr_len,
  // architectural state
  output logic [7:0] acc,
  output logic [7:0] second,
  output logic [7:0] psw,
  output logic [15:0] data_pointer,
  // write back of a direct, bank or indirect destination byte
  output logic wb_valid,
  output logic [7:0] wb_data
);
  ////////////////////////////////////////////////////////////////////////
  aat_pkg::aat_state_t state, next_state;
  logic [3:0] count, next_count, cyc_need;
  logic [1:0] next_instr_len, len_need;
  aat_pkg::aat_op_t op_q, next_op_q;
  aat_pkg::aat_form_t form_q, next_form_q;
  logic [7:0] opnd_q, next_opnd_q;
  logic [7:0] next_acc, next_second, next_psw, next_wb_data;
  logic [15:0] next_data_pointer;
  logic next_wb_valid;

  // cycle count and byte length per operation and operand form
  always_comb begin
    cyc_need = aat_pkg::AAT_CYC_2;
    len_need = aat_pkg::AAT_LEN_2;
    case (form)
      aat_pkg::AAT_SRC_ACC, aat_pkg::AAT_SRC_BANK: begin
        cyc_need = aat_pkg::AAT_CYC_1;
        len_need = aat_pkg::AAT_LEN_1;
      end
      aat_pkg::AAT_SRC_INDIRECT: begin
        cyc_need = aat_pkg::AAT_CYC_2;
        len_need = aat_pkg::AAT_LEN_1;
      end
      aat_pkg::AAT_SRC_IMM_TO_DIRECT: begin
        cyc_need = aat_pkg::AAT_CYC_3;
        len_need = aat_pkg::AAT_LEN_3;
      end
      default: begin
        cyc_need = aat_pkg::AAT_CYC_2;
        len_need = aat_pkg::AAT_LEN_2;
      end
    endcase
    case (op)
      aat_pkg::AAT_OP_INC_DP, aat_pkg::AAT_OP_DADJ: begin
        cyc_need = aat_pkg::AAT_CYC_1;
        len_need = aat_pkg::AAT_LEN_1;
      end
      aat_pkg::AAT_OP_MUL: begin
        cyc_need = aat_pkg::AAT_CYC_MUL;
        len_need = aat_pkg::AAT_LEN_1;
      end
      aat_pkg::AAT_OP_DIV: begin
        cyc_need = aat_pkg::AAT_CYC_DIV;
        len_need = aat_pkg::AAT_LEN_1;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing: results commit in the final cycle, so done marks completion
  always_comb begin
    next_state = state;
    next_count = count;
    next_op_q = op_q;
    next_form_q = form_q;
    next_opnd_q = opnd_q;
    next_instr_len = instr_len;
    case (state)
      aat_pkg::AAT_IDLE, aat_pkg::AAT_DONE: begin
        next_state = aat_pkg::AAT_IDLE;
        if (start) begin
          next_op_q = op;
          next_form_q = form;
          next_opnd_q = operand;
          next_instr_len = len_need;
          next_count = cyc_need - 4'h1;
          next_state = (cyc_need == aat_pkg::AAT_CYC_1) ? aat_pkg::AAT_DONE : aat_pkg::AAT_BUSY;
        end
      end
      aat_pkg::AAT_BUSY: begin
        next_count = count - 4'h1;
        if (count == 4'h1) begin
          next_state = aat_pkg::AAT_DONE;
        end
      end
      default: begin
        next_state = aat_pkg::AAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= aat_pkg::AAT_IDLE;
      count <= 4'h0;
      op_q <= aat_pkg::AAT_OP_ADD;
      form_q <= aat_pkg::AAT_SRC_ACC;
      opnd_q <= 8'h00;
      instr_len <= 2'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      op_q <= next_op_q;
      form_q <= next_form_q;
      opnd_q <= next_opnd_q;
      instr_len <= next_instr_len;
    end
  end

  // issue is accepted only when idle or in the completion cycle
  assign busy = (state == aat_pkg::AAT_BUSY);
  assign done = (state == aat_pkg::AAT_DONE);

  ////////////////////////////////////////////////////////////////////////
  // datapath, evaluated on the cycle that enters DONE
  logic commit;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [15:0] prod;
  logic [7:0] dest, logic_res, step_res;
  logic carry_in;
  logic [8:0] adj_tmp;
  // second is loaded outside this block, so a non-acc form brings its value in operand
  logic [7:0] factor;
  assign commit = (next_state == aat_pkg::AAT_DONE);

  always_comb begin
    next_acc = acc;
    next_second = second;
    next_psw = psw;
    next_data_pointer = data_pointer;
    next_wb_valid = 1'b0;
    next_wb_data = wb_data;
    sum9 = 9'h000;
    sum5 = 5'h00;
    prod = 16'h0000;
    adj_tmp = 9'h000;
    carry_in = psw[aat_pkg::AAT_FLAG_CY];
    factor = (next_form_q == aat_pkg::AAT_SRC_ACC) ? second : next_opnd_q;
    dest = (next_form_q == aat_pkg::AAT_SRC_ACC) ? acc : next_opnd_q;
    logic_res = 8'h00;
    step_res = 8'h00;
    if (commit) begin
      case (next_op_q)
        aat_pkg::AAT_OP_ADD, aat_pkg::AAT_OP_ADD_CARRY: begin
          if (next_op_q == aat_pkg::AAT_OP_ADD) begin
            carry_in = 1'b0;
          end
          sum9 = {1'b0, acc} + {1'b0, next_opnd_q} + {8'h00, carry_in};
          sum5 = {1'b0, acc[3:0]} + {1'b0, next_opnd_q[3:0]} + {4'h0, carry_in};
          next_acc = sum9[7:0];
          next_psw[aat_pkg::AAT_FLAG_CY] = sum9[8];
          next_psw[aat_pkg::AAT_FLAG_AC] = sum5[4];
          next_psw[aat_pkg::AAT_FLAG_OV] = (acc[7] == next_opnd_q[7]) && (sum9[7] != acc[7]);
        end
        aat_pkg::AAT_OP_SUB_BORROW: begin
          sum9 = {1'b0, acc} - {1'b0, next_opnd_q} - {8'h00, carry_in};
          sum5 = {1'b0, acc[3:0]} - {1'b0, next_opnd_q[3:0]} - {4'h0, carry_in};
          next_acc = sum9[7:0];
          next_psw[aat_pkg::AAT_FLAG_CY] = sum9[8];
          next_psw[aat_pkg::AAT_FLAG_AC] = sum5[4];
          next_psw[aat_pkg::AAT_FLAG_OV] = (acc[7] != next_opnd_q[7]) && (sum9[7] != acc[7]);
        end
        aat_pkg::AAT_OP_INC, aat_pkg::AAT_OP_DEC: begin
          // flags untouched, as with the classic core
          step_res = (next_op_q == aat_pkg::AAT_OP_INC) ? dest + 8'h01 : dest - 8'h01;
          if (next_form_q == aat_pkg::AAT_SRC_ACC) begin
            next_acc = step_res;
          end else begin
            next_wb_valid = 1'b1;
            next_wb_data = step_res;
          end
        end
        aat_pkg::AAT_OP_INC_DP: begin
          next_data_pointer = data_pointer + 16'h0001;
        end
        aat_pkg::AAT_OP_MUL: begin
          prod = {8'h00, acc} * {8'h00, factor};
          next_acc = prod[7:0];
          next_second = prod[15:8];
          next_psw[aat_pkg::AAT_FLAG_CY] = 1'b0;
          next_psw[aat_pkg::AAT_FLAG_OV] = (prod[15:8] != 8'h00);
        end
        aat_pkg::AAT_OP_DIV: begin
          // divide by zero leaves both registers, flags overflow
          next_psw[aat_pkg::AAT_FLAG_CY] = 1'b0;
          next_psw[aat_pkg::AAT_FLAG_OV] = (factor == 8'h00);
          if (factor != 8'h00) begin
            next_acc = acc / factor;
            next_second = acc % factor;
          end
        end
        aat_pkg::AAT_OP_DADJ: begin
          adj_tmp = {1'b0, acc};
          if (acc[3:0] > 4'h9 || psw[aat_pkg::AAT_FLAG_AC]) begin
            adj_tmp = adj_tmp + 9'h006;
          end
          if (adj_tmp[8] || psw[aat_pkg::AAT_FLAG_CY] || adj_tmp[7:4] > 4'h9) begin
            adj_tmp = adj_tmp + 9'h060;
          end
          next_acc = adj_tmp[7:0];
          next_psw[aat_pkg::AAT_FLAG_CY] = adj_tmp[8] | psw[aat_pkg::AAT_FLAG_CY];
        end
        default: begin
          // logical group; flags deliberately untouched
          case (next_op_q)
            aat_pkg::AAT_OP_AND: logic_res = acc & next_opnd_q;
            aat_pkg::AAT_OP_OR: logic_res = acc | next_opnd_q;
            default: logic_res = acc ^ next_opnd_q;
          endcase
          if (next_form_q == aat_pkg::AAT_SRC_ACC_TO_DIRECT ||
              next_form_q == aat_pkg::AAT_SRC_IMM_TO_DIRECT) begin
            next_wb_valid = 1'b1;
            next_wb_data = logic_res;
          end else begin
            next_acc = logic_res;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      acc <= aat_pkg::AAT_ACC_RESET;
      second <= aat_pkg::AAT_SECOND_RESET;
      psw <= aat_pkg::AAT_PSW_RESET;
      data_pointer <= aat_pkg::AAT_POINTER_RESET;
      wb_valid <= 1'b0;
      wb_data <= 8'h00;
    end else begin
      acc <= next_acc;
      second <= next_second;
      psw <= next_psw;
      data_pointer <= next_data_pointer;
      wb_valid <= next_wb_valid;
      wb_data <= next_wb_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single-cycle issue completes on the next edge
  one_cycle_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && !busy && form == aat_pkg::AAT_SRC_BANK && op == aat_pkg::AAT_OP_ADD)
    |=> done) else $error("one-cycle add did not complete");
  mul_four_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && !busy && op == aat_pkg::AAT_OP_MUL) |=> busy [*3] ##1 done)
    else $error("multiply not four cycles");
  div_eight_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && !busy && op == aat_pkg::AAT_OP_DIV) |=> busy [*7] ##1 done)
    else $error("divide not eight cycles");
  imm_direct_three_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && !busy && form == aat_pkg::AAT_SRC_IMM_TO_DIRECT && op == aat_pkg::AAT_OP_OR)
    |=> busy [*2] ##1 (done && wb_valid && instr_len == 2'h3))
    else $error("immediate to direct not three cycles");
  pointer_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && !busy && op == aat_pkg::AAT_OP_INC_DP)
    |=> (done && data_pointer == $past(data_pointer) + 16'h0001))
    else $error("data pointer step wrong");
  logic_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && !busy && op == aat_pkg::AAT_OP_XOR) |=> ##[0:1] (done && $stable(psw)))
    else $error("logical operation touched flags");
  indirect_two_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && !busy && form == aat_pkg::AAT_SRC_INDIRECT && op == aat_pkg::AAT_OP_SUB_BORROW)
    |=> busy ##1 done) else $error("indirect subtract not two cycles");
  done_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
    done |-> !$past(done) || $past(start)) else $error("done held without issue");
  cov_mul_c: cover property (@(posedge mclk) disable iff (!rst_b)
    start && op == aat_pkg::AAT_OP_MUL ##4 done);
  cov_div_c: cover property (@(posedge mclk) disable iff (!rst_b)
    start && op == aat_pkg::AAT_OP_DIV ##8 done);
  cov_b2b_c: cover property (@(posedge mclk) disable iff (!rst_b) done && start ##1 done);
endmodule

// *** hw/aat_pkg.sv ***
// aat_pkg: opcodes, operand forms, flag positions and cycle counts of the execution datapath
package aat_pkg;
  typedef enum logic [3:0] {
    AAT_OP_ADD = 4'h0,
    AAT_OP_ADD_CARRY = 4'h1,
    AAT_OP_SUB_BORROW = 4'h2,
    AAT_OP_INC = 4'h3,
    AAT_OP_DEC = 4'h4,
    AAT_OP_INC_DP = 4'h5,
    AAT_OP_MUL = 4'h6,
    AAT_OP_DIV = 4'h7,
    AAT_OP_DADJ = 4'h8,
    AAT_OP_AND = 4'h9,
    AAT_OP_OR = 4'hA,
    AAT_OP_XOR = 4'hB
  } aat_op_t;
  typedef enum logic [2:0] {
    AAT_SRC_ACC = 3'h0,
    AAT_SRC_BANK = 3'h1,
    AAT_SRC_INDIRECT = 3'h2,
    AAT_SRC_DIRECT = 3'h3,
    AAT_SRC_IMM = 3'h4,
    AAT_SRC_ACC_TO_DIRECT = 3'h5,
    AAT_SRC_IMM_TO_DIRECT = 3'h6
  } aat_form_t;
  typedef enum logic [2:0] {
    AAT_IDLE = 3'b001,
    AAT_BUSY = 3'b010,
    AAT_DONE = 3'b100
  } aat_state_t;
  localparam int AAT_FLAG_CY = 7;
  localparam int AAT_FLAG_AC = 6;
  localparam int AAT_FLAG_OV = 2;
  localparam logic [7:0] AAT_ACC_RESET = 8'h00;
  localparam logic [7:0] AAT_SECOND_RESET = 8'h00;
  localparam logic [7:0] AAT_PSW_RESET = 8'h00;
  localparam logic [15:0] AAT_POINTER_RESET = 16'h0000;
  localparam logic [3:0] AAT_CYC_1 = 4'h1;
  localparam logic [3:0] AAT_CYC_2 = 4'h2;
  localparam logic [3:0] AAT_CYC_3 = 4'h3;
  localparam logic [3:0] AAT_CYC_MUL = 4'h4;
  localparam logic [3:0] AAT_CYC_DIV = 4'h8;
  localparam logic [1:0] AAT_LEN_1 = 2'h1;
  localparam logic [1:0] AAT_LEN_2 = 2'h2;
  localparam logic [1:0] AAT_LEN_3 = 2'h3;
endpackage

// *** tb/aat_alu_bench.sv ***
// aat_alu_bench: self-checking bench for execution timing and results of the datapath
`timescale 1ns/1ns
module aat_alu_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  aat_pkg::aat_op_t op = aat_pkg::AAT_OP_ADD;
  aat_pkg::aat_form_t form = aat_pkg::AAT_SRC_BANK;
  logic [7:0] operand = 8'h00;
  logic busy, done, wb_valid;
  logic [1:0] instr_len;
  logic [7:0] acc, second, psw, wb_data;
  logic [15:0] data_pointer;
  int n_mismatch = 0;
  int compares = 0;

  always #5 mclk = ~mclk;

  aat_alu aat_alu_inst (.mclk(mclk), .rst_b(rst_b), .start(start), .op(op), .form(form),
    .operand(operand), .busy(busy), .done(done), .instr_len(instr_len), .acc(acc),
    .second(second), .psw(psw), .data_pointer(data_pointer), .wb_valid(wb_valid),
    .wb_data(wb_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic flags(input logic [7:0] mask, input logic [7:0] exp);
    chk("status flags", {8'h00, exp}, {8'h00, psw & mask});
  endtask

  // op and form given as package codes; operands held until the next issue
  task automatic exec(input logic [3:0] o, input logic [2:0] f, input logic [7:0] v,
      input logic [3:0] nc, input logic [1:0] nl, input logic tw, input logic [7:0] ex);
    int cnt;
    @(negedge mclk);
    start = 1'b1;
    op = aat_pkg::aat_op_t'(o);
    form = aat_pkg::aat_form_t'(f);
    operand = v;
    @(negedge mclk);
    start = 1'b0;
    cnt = 1;
    // bounded wait, a lost done must not hang the run
    while (done !== 1'b1 && cnt < 20) begin
      @(negedge mclk);
      cnt++;
    end
    chk("cycles", {12'h0, nc}, 16'(cnt));
    chk("length", {14'h0, nl}, {14'h0, instr_len});
    chk("write back valid", {15'h0, tw}, {15'h0, wb_valid});
    chk("result", {8'h00, ex}, {8'h00, tw ? wb_data : acc});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("idle flags", 16'h0000, {13'h0, busy, done, wb_valid});
    chk("acc and second", 16'h0000, {acc, second});
    chk("psw", 16'h0000, {8'h00, psw});
    chk("data pointer", 16'h0000, data_pointer);
    chk("length", 16'h0000, {14'h0, instr_len});
    $display("test reset done");
  endtask

  task automatic t_add;
    exec(4'h0, 3'h1, 8'h7F, 4'h1, 2'h1, 1'b0, 8'h7F);
    flags(8'hC4, 8'h00);
    exec(4'h0, 3'h4, 8'h01, 4'h2, 2'h2, 1'b0, 8'h80);
    flags(8'hC4, 8'h44);
    exec(4'h0, 3'h3, 8'h80, 4'h2, 2'h2, 1'b0, 8'h00);
    flags(8'hC4, 8'h84);
    exec(4'h0, 3'h2, 8'h05, 4'h2, 2'h1, 1'b0, 8'h05);
    exec(4'h0, 3'h1, 8'hFF, 4'h1, 2'h1, 1'b0, 8'h04);
    flags(8'hC4, 8'hC0);
    exec(4'h1, 3'h2, 8'h10, 4'h2, 2'h1, 1'b0, 8'h15);
    flags(8'hC4, 8'h00);
    exec(4'h1, 3'h1, 8'h01, 4'h1, 2'h1, 1'b0, 8'h16);
    exec(4'h1, 3'h3, 8'h02, 4'h2, 2'h2, 1'b0, 8'h18);
    exec(4'h1, 3'h4, 8'h08, 4'h2, 2'h2, 1'b0, 8'h20);
    flags(8'hC4, 8'h40);
    $display("test add done");
  endtask

  task automatic t_sub_borrow;
    exec(4'h2, 3'h1, 8'h21, 4'h1, 2'h1, 1'b0, 8'hFF);
    flags(8'hC4, 8'hC0);
    exec(4'h2, 3'h4, 8'h0F, 4'h2, 2'h2, 1'b0, 8'hEF);
    flags(8'hC4, 8'h40);
    exec(4'h2, 3'h3, 8'h6F, 4'h2, 2'h2, 1'b0, 8'h80);
    flags(8'hC4, 8'h00);
    exec(4'h2, 3'h2, 8'h01, 4'h2, 2'h1, 1'b0, 8'h7F);
    flags(8'hC4, 8'h44);
    $display("test subtract done");
  endtask

  task automatic t_incdec;
    exec(4'h3, 3'h0, 8'h00, 4'h1, 2'h1, 1'b0, 8'h80);
    exec(4'h4, 3'h0, 8'h00, 4'h1, 2'h1, 1'b0, 8'h7F);
    exec(4'h3, 3'h1, 8'hFF, 4'h1, 2'h1, 1'b1, 8'h00);
    exec(4'h3, 3'h3, 8'h41, 4'h2, 2'h2, 1'b1, 8'h42);
    exec(4'h3, 3'h2, 8'h09, 4'h2, 2'h1, 1'b1, 8'h0A);
    exec(4'h4, 3'h1, 8'h00, 4'h1, 2'h1, 1'b1, 8'hFF);
    exec(4'h4, 3'h3, 8'h10, 4'h2, 2'h2, 1'b1, 8'h0F);
    exec(4'h4, 3'h2, 8'h01, 4'h2, 2'h1, 1'b1, 8'h00);
    flags(8'hC4, 8'h44);
    exec(4'h5, 3'h0, 8'h00, 4'h1, 2'h1, 1'b0, 8'h7F);
    exec(4'h5, 3'h0, 8'h00, 4'h1, 2'h1, 1'b0, 8'h7F);
    chk("data pointer", 16'h0002, data_pointer);
    $display("test increment decrement done");
  endtask

  task automatic t_logic;
    exec(4'h9, 3'h1, 8'h0F, 4'h1, 2'h1, 1'b0, 8'h0F);
    exec(4'hA, 3'h3, 8'h80, 4'h2, 2'h2, 1'b0, 8'h8F);
    exec(4'hB, 3'h4, 8'hFF, 4'h2, 2'h2, 1'b0, 8'h70);
    exec(4'h9, 3'h2, 8'h7C, 4'h2, 2'h1, 1'b0, 8'h70);
    exec(4'hA, 3'h1, 8'h03, 4'h1, 2'h1, 1'b0, 8'h73);
    exec(4'hB, 3'h2, 8'h13, 4'h2, 2'h1, 1'b0, 8'h60);
    exec(4'h9, 3'h3, 8'hF0, 4'h2, 2'h2, 1'b0, 8'h60);
    exec(4'hA, 3'h4, 8'h01, 4'h2, 2'h2, 1'b0, 8'h61);
    exec(4'h9, 3'h5, 8'hF0, 4'h2, 2'h2, 1'b1, 8'h60);
    exec(4'h9, 3'h6, 8'h0F, 4'h3, 2'h3, 1'b1, 8'h01);
    exec(4'hA, 3'h5, 8'h10, 4'h2, 2'h2, 1'b1, 8'h71);
    exec(4'hA, 3'h6, 8'h80, 4'h3, 2'h3, 1'b1, 8'hE1);
    exec(4'hB, 3'h5, 8'hFF, 4'h2, 2'h2, 1'b1, 8'h9E);
    exec(4'hB, 3'h3, 8'h61, 4'h2, 2'h2, 1'b0, 8'h00);
    exec(4'hB, 3'h1, 8'h5A, 4'h1, 2'h1, 1'b0, 8'h5A);
    exec(4'h9, 3'h4, 8'h0F, 4'h2, 2'h2, 1'b0, 8'h0A);
    exec(4'hA, 3'h2, 8'h50, 4'h2, 2'h1, 1'b0, 8'h5A);
    flags(8'hC4, 8'h44);
    $display("test logic done");
  endtask

  // acc form uses second itself; a bank form hands in second's value for real results
  task automatic t_muldiv;
    exec(4'h6, 3'h0, 8'h00, 4'h4, 2'h1, 1'b0, 8'h00);
    chk("second", 16'h0000, {8'h00, second});
    flags(8'h84, 8'h00);
    exec(4'h0, 3'h1, 8'h35, 4'h1, 2'h1, 1'b0, 8'h35);
    exec(4'h7, 3'h0, 8'h00, 4'h8, 2'h1, 1'b0, 8'h35);
    flags(8'h84, 8'h04);
    exec(4'h6, 3'h1, 8'h10, 4'h4, 2'h1, 1'b0, 8'h50);
    chk("second", 16'h0003, {8'h00, second});
    flags(8'h84, 8'h04);
    exec(4'h7, 3'h1, 8'h09, 4'h8, 2'h1, 1'b0, 8'h08);
    chk("second", 16'h0008, {8'h00, second});
    flags(8'h84, 8'h00);
    $display("test multiply divide done");
  endtask

  // start held through a multiply: refused while busy, taken again in the done cycle
  task automatic t_back_to_back;
    @(negedge mclk);
    start = 1'b1;
    op = aat_pkg::AAT_OP_MUL;
    form = aat_pkg::AAT_SRC_ACC;
    for (int i = 1; i <= 10; i++) begin
      @(negedge mclk);
      if (i == 5) start = 1'b0;
      chk("done pulse", {15'h0, (i == 4 || i == 8)}, {15'h0, done});
    end
    @(negedge mclk);
    start = 1'b1;
    op = aat_pkg::AAT_OP_ADD;
    form = aat_pkg::AAT_SRC_BANK;
    operand = 8'h01;
    @(negedge mclk);
    chk("done first", 16'h0001, {15'h0, done});
    @(negedge mclk);
    start = 1'b0;
    chk("done second", 16'h0001, {15'h0, done});
    chk("acc", 16'h0002, {8'h00, acc});
    $display("test back to back done");
  endtask

  task automatic t_dadj;
    exec(4'h0, 3'h1, 8'h3A, 4'h1, 2'h1, 1'b0, 8'h3C);
    exec(4'h8, 3'h0, 8'h00, 4'h1, 2'h1, 1'b0, 8'h42);
    exec(4'h0, 3'h1, 8'h99, 4'h1, 2'h1, 1'b0, 8'hDB);
    exec(4'h8, 3'h0, 8'h00, 4'h1, 2'h1, 1'b0, 8'h41);
    flags(8'h80, 8'h80);
    $display("test decimal adjust done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    t_reset;
    t_add;
    t_sub_borrow;
    t_incdec;
    t_logic;
    t_muldiv;
    t_back_to_back;
    t_dadj;
    test_done;
  end

  // about 170 cycles expected; far longer means a hang
  initial begin
    #100000;
    n_mismatch++;
    $display("watchdog expired");
    test_done;
  end
endmodule
